// ===== design/async_serial_receiver.v
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "async_rx_map.vh"

// Summary of operation
// - a falling edge on rx starts reception; the start bit is then tested
// - after a good start bit, eight data bits shift in, lsb first
// - holding register and shift register are both eight bits wide
// - stop bits expected follow the control setting; sender must send them
// - bad stop bit sets framing error, raises irq, hunts for next start
// - good stop bit copies shift register to holding register and raises irq
// - loading sets data ready; reading holding register clears it
// - shift register is free for the next character right after transfer
// - loading before previous character read sets overrun flag
// - after a character the receiver idles until the next falling edge
// - control setting selects one or two stop bits
// - break on rx sets break flag and raises the port irq
// - overrun raises irq; receive irqs suppressed by the mask bit
module async_serial_receiver #(
   parameter BAUD_W = `BAUD_DIV_W,
   parameter [`BAUD_DIV_W-1:0] BAUD_DIV = `BAUD_DIV_DEF
) (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire rx,
   output wire async_port_irq,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_START = 3'd1;
   localparam [2:0] S_DATA = 3'd2;
   localparam [2:0] S_STOP1 = 3'd3;
   localparam [2:0] S_STOP2 = 3'd4;
   localparam [2:0] S_BREAK = 3'd5;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [2:0] state_q;
   reg [7:0] rx_shift_reg;
   reg [2:0] bit_cnt_q;
   reg [7:0] rx_holding_reg;
   reg rx_data_ready_flag;
   reg overrun_flag;
   reg framing_error_flag;
   reg break_flag;
   reg irq_flag_reg;
   reg [31:0] async_port_control;
   reg rx_prev_q;
   reg all_zero_q;
   reg [3:0] aw_addr_q;
   reg aw_full_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_full_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;

   wire rx_s;
   wire enable;
   wire stop_bit_select;
   wire rx_irq_mask_bit;
   wire half_tick;
   wire fall;
   wire restart;
   wire [31:0] port_status_reg;
   assign enable = async_port_control[`CTL_ENABLE];
   assign stop_bit_select = async_port_control[`CTL_STOP_TWO];
   assign rx_irq_mask_bit = async_port_control[`CTL_RX_IRQ_MASK];

   // ----------------------------------------
   // rx pin synchroniser and bit timing
   // ----------------------------------------
   rx_sync2 #(.RESET_VAL(1'b1)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .d(rx),
      .q(rx_s)
   );

   assign fall = rx_prev_q && !rx_s;
   assign restart = (state_q == S_IDLE) || (state_q == S_BREAK);

   baud_tick_gen #(.W(BAUD_W)) u_baud (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .restart(restart),
      .period(BAUD_DIV),
      .half_tick(half_tick),
      .full_tick()
   );

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire wr_go;
   wire rd_go;
   wire rd_holding;
   wire wr_status;
   wire wr_control;
   assign s_axi_awready = ce && !aw_full_q && !bvalid_q;
   assign s_axi_wready = ce && !w_full_q && !bvalid_q;
   assign wr_go = aw_full_q && w_full_q && !bvalid_q;
   assign s_axi_arready = ce && !rvalid_q;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign rd_holding = ce && rd_go && (s_axi_araddr == `ADDR_RX_HOLDING);
   assign wr_status = ce && wr_go && (aw_addr_q == `ADDR_STATUS) && w_strb_q[0];
   assign wr_control = ce && wr_go && (aw_addr_q == `ADDR_CONTROL);

   // ----------------------------------------
   // receive state machine
   // ----------------------------------------
   reg load_ok;
   reg load_fe;
   reg brk_ev;
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= S_IDLE;
         rx_shift_reg <= 8'h00;
         bit_cnt_q <= 3'd0;
         rx_prev_q <= 1'b1;
         all_zero_q <= 1'b0;
         load_ok <= 1'b0;
         load_fe <= 1'b0;
         brk_ev <= 1'b0;
      end else if (ce) begin
         rx_prev_q <= rx_s;
         load_ok <= 1'b0;
         load_fe <= 1'b0;
         brk_ev <= 1'b0;
         if (!enable) begin
            state_q <= S_IDLE;
         end else begin
            case (state_q)
               S_IDLE: begin
                  if (fall) begin
                     state_q <= S_START;
                  end
               end
               S_START: begin
                  if (half_tick) begin
                     if (!rx_s) begin
                        state_q <= S_DATA;
                        bit_cnt_q <= 3'd0;
                        all_zero_q <= 1'b1;
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_DATA: begin
                  if (half_tick) begin
                     rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
                     all_zero_q <= all_zero_q && !rx_s;
                     bit_cnt_q <= bit_cnt_q + 3'd1;
                     if (bit_cnt_q == 3'd7) begin
                        state_q <= S_STOP1;
                     end
                  end
               end
               S_STOP1: begin
                  if (half_tick) begin
                     if (!rx_s) begin
                        load_fe <= 1'b1;
                        if (all_zero_q) begin
                           brk_ev <= 1'b1;
                           state_q <= S_BREAK;
                        end else begin
                           state_q <= S_IDLE;
                        end
                     end else if (stop_bit_select) begin
                        state_q <= S_STOP2;
                     end else begin
                        load_ok <= 1'b1;
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_STOP2: begin
                  if (half_tick) begin
                     if (!rx_s) begin
                        load_fe <= 1'b1;
                     end else begin
                        load_ok <= 1'b1;
                     end
                     state_q <= S_IDLE;
                  end
               end
               S_BREAK: begin
                  if (rx_s) begin
                     state_q <= S_IDLE;
                  end
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // holding register and status flags
   // ----------------------------------------
   wire [7:0] wclr;
   wire rx_event;
   assign wclr = wr_status ? w_data_q[7:0] : 8'h00;
   assign rx_event = load_ok || load_fe || brk_ev || (load_ok && rx_data_ready_flag);
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_holding_reg <= 8'h00;
         rx_data_ready_flag <= 1'b0;
         overrun_flag <= 1'b0;
         framing_error_flag <= 1'b0;
         break_flag <= 1'b0;
         irq_flag_reg <= 1'b0;
      end else if (ce) begin
         if (load_ok) begin
            rx_holding_reg <= rx_shift_reg;
            rx_data_ready_flag <= 1'b1;
         end else if (rd_holding) begin
            rx_data_ready_flag <= 1'b0;
         end
         if (load_ok && rx_data_ready_flag && !rd_holding) begin
            overrun_flag <= 1'b1;
         end else if (wclr[`ST_OVERRUN]) begin
            overrun_flag <= 1'b0;
         end
         if (load_fe) begin
            framing_error_flag <= 1'b1;
         end else if (wclr[`ST_FRAMING]) begin
            framing_error_flag <= 1'b0;
         end
         if (brk_ev) begin
            break_flag <= 1'b1;
         end else if (wclr[`ST_BREAK]) begin
            break_flag <= 1'b0;
         end
         if (rx_event && !rx_irq_mask_bit) begin
            irq_flag_reg <= 1'b1;
         end else if (wclr[`ST_IRQ_PEND]) begin
            irq_flag_reg <= 1'b0;
         end
      end
   end
   assign async_port_irq = irq_flag_reg;

   assign port_status_reg = {26'h000_0000, (state_q != S_IDLE), irq_flag_reg,
      break_flag, framing_error_flag, overrun_flag, rx_data_ready_flag};

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_q <= 4'h0;
         aw_full_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `OKAY_RESP;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `OKAY_RESP;
         async_port_control <= `CTL_RESET_VAL;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_full_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_full_q <= 1'b1;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            if (aw_addr_q == `ADDR_STATUS || aw_addr_q == `ADDR_CONTROL) begin
               bresp_q <= `OKAY_RESP;
            end else begin
               bresp_q <= `SLVERR_RESP;
            end
            if (wr_control && w_strb_q[0]) begin
               async_port_control <= {29'h0000_0000, w_data_q[2:0]};
            end
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= `OKAY_RESP;
            case (s_axi_araddr)
               `ADDR_RX_HOLDING: rdata_q <= {24'h00_0000, rx_holding_reg};
               `ADDR_STATUS: rdata_q <= port_status_reg;
               `ADDR_CONTROL: rdata_q <= async_port_control;
               default: begin
                  rdata_q <= 32'h0000_0000;
                  rresp_q <= `SLVERR_RESP;
               end
            endcase
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule

// ===== design/baud_tick_gen.v
`timescale 1ns/100ps
module baud_tick_gen #(
   parameter W = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire restart,
   input wire [W-1:0] period,
   output wire half_tick,
   output wire full_tick
);
   reg [W-1:0] cnt_q;
   wire [W-1:0] half;
   assign half = {1'b0, period[W-1:1]};
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= {W{1'b0}};
      end else if (ce) begin
         if (restart || full_tick) begin
            cnt_q <= {W{1'b0}};
         end else begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
   assign half_tick = ce && !restart && (cnt_q == half);
   assign full_tick = ce && !restart && (cnt_q == period - {{(W-1){1'b0}}, 1'b1});
endmodule

// ===== design/rx_sync2.v
`timescale 1ns/100ps
module rx_sync2 #(
   parameter RESET_VAL = 1'b1
) (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire d,
   output wire q
);
   reg s1_q;
   reg s2_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
      end else if (ce) begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end
   assign q = s2_q;
endmodule

// ===== dv/rx_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// receiver port checks
// ----------------------------------------
module rx_props #(
   parameter BAUD_DIV = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire rx,
   input wire async_port_irq,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   reg [11:0] hi_q;
   reg [3:0] ar_q;
   always @(posedge aclk) begin
      if (!aresetn || !rx) hi_q <= 12'h000;
      else if (hi_q != 12'hfff) hi_q <= hi_q + 12'h001;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
   end
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped before bready");
   a_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_rresp_map: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rresp ==
      ((ar_q == 4'h0 || ar_q == 4'h4 || ar_q == 4'h8) ? 2'b00 : 2'b10))
      else $error("read response code wrong");
   a_hold_width: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr == 4'h0 |=> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("holding wider than a byte");
   a_idle_irq: assert property (hi_q > 10 * BAUD_DIV + 8 |-> !$rose(async_port_irq))
      else $error("irq raised on an idle line");
   c_irq: cover property ($rose(async_port_irq));
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ===== dv/serial_tx_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// remote serial sender
// ----------------------------------------
module serial_tx_model #(
   parameter BIT_CYC = 16
) (
   input wire aclk,
   input wire go,
   input wire [7:0] data,
   input wire two_stop,
   input wire bad_stop,
   output reg tx,
   output reg busy
);
   reg [10:0] sh_q;
   reg [3:0] nb_q;
   integer cnt_q;
   initial begin
      tx = 1'b1;
      busy = 1'b0;
   end
   always @(posedge aclk) begin
      if (go && !busy) begin
         sh_q <= {1'b1, ~bad_stop, data, 1'b0};
         nb_q <= two_stop ? 4'hb : 4'ha;
         cnt_q <= 0;
         busy <= 1'b1;
         tx <= 1'b0;
      end else if (busy && cnt_q == BIT_CYC - 1) begin
         cnt_q <= 0;
         nb_q <= nb_q - 4'h1;
         sh_q <= sh_q >> 1;
         tx <= (nb_q == 4'h1) ? 1'b1 : sh_q[1];
         busy <= (nb_q != 4'h1);
      end else if (busy) begin
         cnt_q <= cnt_q + 1;
      end
   end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`include "async_rx_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   localparam int BD = 16;
   reg aclk = 0, aresetn = 0, go = 0, two = 0, bad = 0, gl_n = 1, ce = 1;
   reg [7:0] txd = 0, c = 0, c2 = 0;
   reg [3:0] awaddr = 0, araddr = 0;
   reg [31:0] wdata = 0, d = 0;
   reg [1:0] r = 0, b = 0;
   reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   wire awready, wready, bvalid, arready, rvalid, irq, tx, busy;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire rx = tx & gl_n;
   int n_errors = 0, checked = 0, i;
   always #2.5 aclk = ~aclk;
   async_serial_receiver #(.BAUD_DIV(16'(BD))) u_dut (.aclk(aclk), .aresetn(aresetn),
      .ce(ce), .rx(rx), .async_port_irq(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   serial_tx_model #(.BIT_CYC(BD)) u_tx (.aclk(aclk), .go(go), .data(txd),
      .two_stop(two), .bad_stop(bad), .tx(tx), .busy(busy));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task report_and_stop;
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task timeout;
      n_errors++;
      report_and_stop;
   endtask
   function [4:0] st(input dr, ov, fe, bk, ip);
      st = {ip, bk, fe, ov, dr};
   endfunction
   task wr(input [3:0] a, input [31:0] v);
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid) break;
      end
      b = bresp;
      bready <= 0;
      if (k == 100) timeout;
   endtask
   task rd(input [3:0] a);
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 0;
      if (k == 100) timeout;
   endtask
   task send(input [7:0] v, input b);
      int k;
      @(posedge aclk);
      txd <= v;
      bad <= b;
      go <= 1;
      @(posedge aclk);
      go <= 0;
      for (k = 0; k < 13 * BD && (busy || k < 2); k++) @(posedge aclk);
      if (k == 13 * BD) timeout;
      repeat (4) @(posedge aclk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      d = $urandom(32'h3402);
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      rd(`ADDR_CONTROL);
      `CHK(d, `CTL_RESET_VAL)
      rd(`ADDR_STATUS);
      `CHK(d[4:0], st(0, 0, 0, 0, 0))
      rd(4'hc);
      `CHK({r, d}, {`SLVERR_RESP, 32'h0000_0000})
      wr(4'hc, 32'h0000_0000);
      `CHK(b, `SLVERR_RESP)
      for (i = 0; i < 8; i++) begin
         c = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         wr(`ADDR_CONTROL, {30'h0000_0000, i[0], 1'b1});
         `CHK(b, `OKAY_RESP)
         two <= i[0];
         send(c, 0);
         `CHK(irq, 1'b1)
         rd(`ADDR_STATUS);
         `CHK(d[4:0], st(1, 0, 0, 0, 1))
         rd(`ADDR_RX_HOLDING);
         `CHK(d, {24'h00_0000, c})
         rd(`ADDR_STATUS);
         `CHK(d[0], 1'b0)
         wr(`ADDR_STATUS, 32'h0000_0010);
         `CHK(irq, 1'b0)
      end
      wr(`ADDR_CONTROL, 32'h0000_0001);
      two <= 0;
      c = 8'($urandom);
      c2 = 8'($urandom);
      send(c, 0);
      send(c2, 0);
      rd(`ADDR_STATUS);
      `CHK(d[4:0], st(1, 1, 0, 0, 1))
      rd(`ADDR_RX_HOLDING);
      `CHK(d[7:0], c2)
      wr(`ADDR_STATUS, 32'h0000_0012);
      send(8'h5a, 1);
      `CHK(irq, 1'b1)
      rd(`ADDR_STATUS);
      `CHK(d[4:0], st(0, 0, 1, 0, 1))
      wr(`ADDR_STATUS, 32'h0000_0014);
      send(8'ha5, 0);
      rd(`ADDR_RX_HOLDING);
      `CHK(d[7:0], 8'ha5)
      wr(`ADDR_STATUS, 32'h0000_0010);
      send(8'h00, 1);
      rd(`ADDR_STATUS);
      `CHK(d[4:0], st(0, 0, 1, 1, 1))
      wr(`ADDR_STATUS, 32'h0000_001c);
      wr(`ADDR_CONTROL, 32'h0000_0005);
      send(c, 0);
      `CHK(irq, 1'b0)
      rd(`ADDR_STATUS);
      `CHK(d[4:0], st(1, 0, 0, 0, 0))
      rd(`ADDR_RX_HOLDING);
      @(posedge aclk);
      gl_n <= 0;
      repeat (2) @(posedge aclk);
      gl_n <= 1;
      repeat (12 * BD) @(posedge aclk);
      rd(`ADDR_STATUS);
      `CHK(d[5:0], 6'h00)
      wr(`ADDR_CONTROL, 32'h0000_0000);
      send(8'h3c, 0);
      rd(`ADDR_STATUS);
      `CHK(d[5:0], 6'h00)
      wr(`ADDR_CONTROL, 32'h0000_0001);
      ce <= 0;
      send(8'h3c, 0);
      `CHK({awready, wready, arready}, 3'b000)
      ce <= 1;
      rd(`ADDR_STATUS);
      `CHK(d[5:0], 6'h00)
      report_and_stop;
   end
endmodule
bind async_serial_receiver rx_props #(.BAUD_DIV(BAUD_DIV)) u_props (.aclk, .aresetn, .rx,
   .async_port_irq, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready);

// ===== pkg/async_rx_map.vh
`ifndef ASYNC_RX_MAP_VH
`define ASYNC_RX_MAP_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_RX_HOLDING 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_CONTROL 4'h8

// ----------------------------------------
// port_status_reg fields
// ----------------------------------------
`define ST_DATA_READY 0
`define ST_OVERRUN 1
`define ST_FRAMING 2
`define ST_BREAK 3
`define ST_IRQ_PEND 4
`define ST_BUSY 5

// ----------------------------------------
// async_port_control fields
// ----------------------------------------
`define CTL_ENABLE 0
`define CTL_STOP_TWO 1
`define CTL_RX_IRQ_MASK 2
`define CTL_RESET_VAL 32'h0000_0001

// ----------------------------------------
// timing and bus response codes
// ----------------------------------------
`define BAUD_DIV_DEF 16'd1736
`define BAUD_DIV_W 16
`define SLVERR_RESP 2'b10
`define OKAY_RESP 2'b00

`endif
